// [logic/rri_pkg.sv]
// Constants shared by the role resolution and interrupt block
package rri_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_AN_CTRL = 8'h00;
  localparam logic [7:0] OFS_AN_STAT = 8'h04;
  localparam logic [7:0] OFS_STS_FLAG = 8'h08;
  localparam logic [7:0] OFS_STS_EN = 8'h0C;
  localparam logic [7:0] OFS_SYS_FLAG = 8'h10;
  localparam logic [7:0] OFS_SYS_EN = 8'h14;
  localparam logic [7:0] OFS_STRAP = 8'h18;
  // Autoneg control fields
  localparam int CTL_PREF = 0;
  localparam int CTL_FORCE = 1;
  localparam int CTL_RESTART = 2;
  // Autoneg status fields
  localparam int STA_DONE = 2;
  localparam int STA_FAIL = 3;
  localparam int STA_LINK = 4;
  localparam int STA_PFORCE = 5;
  localparam int STA_PPREF = 6;
  // PHY status interrupt sources
  localparam int NUM_STS = 4;
  localparam int STS_FRAME = 0;
  localparam int STS_BUF = 1;
  localparam int STS_AN = 2;
  localparam int STS_LINK = 3;
  // System interrupt fields
  localparam int SYS_HWRST = 0;
  localparam int SYS_SW = 1;
  localparam int STRAP_W = 3;
  // Role result encoding
  localparam logic [1:0] ROLE_FOLLOWER = 2'h0;
  localparam logic [1:0] ROLE_LEADER = 2'h1;
  localparam logic [1:0] ROLE_FAULT = 2'h2;
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  typedef enum logic [3:0] {
    AN_IDLE = 4'b0001,
    AN_BUSY = 4'b0010,
    AN_DONE = 4'b0100,
    AN_FAIL = 4'b1000
  } rri_an_state_t;
endpackage

// [logic/rri_sync.sv]
// Two flip-flop synchroniser for pin inputs
module rri_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Not reset, so the pins are already through when reset lifts
  always_ff @(posedge clk)
  begin
    meta_ff <= d;
    q_ff <= meta_ff;
  end

  assign q = q_ff;
endmodule

// [logic/rri_role_resolve.sv]
// Leader/follower resolution with random tie break
module rri_role_resolve (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Advertisements
  input wire logic local_role_forced,
  input wire logic local_prefers_leader,
  input wire logic partner_role_forced,
  input wire logic partner_prefers_leader,
  // Result
  output logic [1:0] role
);
  logic [7:0] lfsr_ff;
  logic [7:0] nxt_lfsr;

  // Free running so a tie can be broken differently on each attempt
  always_comb
  begin
    nxt_lfsr = {lfsr_ff[6:0],
                lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lfsr_ff <= rri_pkg::LFSR_SEED;
    else
      lfsr_ff <= nxt_lfsr;
  end

  always_comb
  begin
    role = rri_pkg::ROLE_FOLLOWER;
    if (local_role_forced && partner_role_forced)
    begin
      if (local_prefers_leader == partner_prefers_leader)
        role = rri_pkg::ROLE_FAULT;
      else if (local_prefers_leader)
        role = rri_pkg::ROLE_LEADER;
    end
    else if (local_role_forced)
    begin
      if (local_prefers_leader)
        role = rri_pkg::ROLE_LEADER;
    end
    else if (partner_role_forced)
    begin
      if (!partner_prefers_leader)
        role = rri_pkg::ROLE_LEADER;
    end
    else if (local_prefers_leader != partner_prefers_leader)
    begin
      if (local_prefers_leader)
        role = rri_pkg::ROLE_LEADER;
    end
    else if (lfsr_ff[0])
      role = rri_pkg::ROLE_LEADER;
  end
endmodule

// [logic/rri_top.sv]
// Role resolution, autoneg outcome and interrupt pin with Wishbone regs
//
// The register addresses and the Wishbone register port were decided locally.
module rri_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Autoneg engine, same clock
  input wire logic an_page_valid,
  input wire logic partner_role_forced,
  input wire logic partner_prefers_leader,
  input wire logic an_link_poor,
  input wire logic an_page_timeout,
  // Event sources, same clock
  input wire logic frame_chk_evt,
  input wire logic buf_err_evt,
  // Pins
  input wire logic phy_addr_strap_bit0,
  input wire logic phy_addr_strap_bit1,
  input wire logic phy_addr_strap_bit2,
  output logic int_n,
  output logic link_up
);
  localparam int NS = rri_pkg::NUM_STS;

  // Bus slave
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic req_w, wr_w;
  logic [7:0] adr8;
  // Control state
  logic lforce_ff, nxt_lforce;
  logic lpref_ff, nxt_lpref;
  logic pforce_ff, nxt_pforce;
  logic ppref_ff, nxt_ppref;
  logic [1:0] role_ff, nxt_role;
  logic [1:0] role_w;
  rri_pkg::rri_an_state_t st_ff, nxt_st;
  logic link_ff, nxt_link;
  logic restart_w;
  // Interrupt state
  logic [NS-1:0] sflag_ff, nxt_sflag, sen_ff, nxt_sen, sevt;
  logic hwf_ff, nxt_hwf, swf_ff, nxt_swf, hwen_ff, nxt_hwen;
  logic swreq_w, irq_n_ff, nxt_irq_n, pend_w;
  // Straps
  logic [rri_pkg::STRAP_W-1:0] strap_s, addr_ff, nxt_addr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction
  rri_sync #(
    .W(rri_pkg::STRAP_W)
  ) u_sync (
    .clk(clk),
    .d({phy_addr_strap_bit2, phy_addr_strap_bit1, phy_addr_strap_bit0}),
    .q(strap_s)
  );
  rri_role_resolve u_res (
    .clk(clk),
    .rst_n(rst_n),
    .local_role_forced(lforce_ff),
    .local_prefers_leader(lpref_ff),
    .partner_role_forced(partner_role_forced),
    .partner_prefers_leader(partner_prefers_leader),
    .role(role_w)
  );

  assign adr8 = 8'(wb_adr_i);
  assign req_w = wb_cyc_i && wb_stb_i && !ack_ff;
  // Every field lives in byte lane 0
  assign wr_w = req_w && wb_we_i && wb_sel_i[0];
  assign restart_w = wr_w && hit(adr8, rri_pkg::OFS_AN_CTRL)
                     && wb_dat_i[rri_pkg::CTL_RESTART];
  assign swreq_w = wr_w && hit(adr8, rri_pkg::OFS_SYS_EN)
                   && wb_dat_i[rri_pkg::SYS_SW];

  // Register access, one cycle answer
  always_comb
  begin
    nxt_ack = req_w;
    nxt_rdat = 32'h0000_0000;
    nxt_lforce = lforce_ff;
    nxt_lpref = lpref_ff;
    nxt_sen = sen_ff;
    nxt_hwen = hwen_ff;
    if (wr_w && hit(adr8, rri_pkg::OFS_AN_CTRL))
    begin
      nxt_lpref = wb_dat_i[rri_pkg::CTL_PREF];
      nxt_lforce = wb_dat_i[rri_pkg::CTL_FORCE];
    end
    if (wr_w && hit(adr8, rri_pkg::OFS_STS_EN))
      nxt_sen = wb_dat_i[NS-1:0];
    if (wr_w && hit(adr8, rri_pkg::OFS_SYS_EN))
      nxt_hwen = wb_dat_i[rri_pkg::SYS_HWRST];
    if (req_w && !wb_we_i)
    begin
      case (adr8)
        rri_pkg::OFS_AN_CTRL:
        begin
          nxt_rdat[rri_pkg::CTL_PREF] = lpref_ff;
          nxt_rdat[rri_pkg::CTL_FORCE] = lforce_ff;
        end
        rri_pkg::OFS_AN_STAT:
        begin
          nxt_rdat[1:0] = role_ff;
          nxt_rdat[rri_pkg::STA_DONE] = (st_ff == rri_pkg::AN_DONE);
          nxt_rdat[rri_pkg::STA_FAIL] = (st_ff == rri_pkg::AN_FAIL);
          nxt_rdat[rri_pkg::STA_LINK] = link_ff;
          nxt_rdat[rri_pkg::STA_PFORCE] = pforce_ff;
          nxt_rdat[rri_pkg::STA_PPREF] = ppref_ff;
        end
        rri_pkg::OFS_STS_FLAG: nxt_rdat[NS-1:0] = sflag_ff;
        rri_pkg::OFS_STS_EN: nxt_rdat[NS-1:0] = sen_ff;
        rri_pkg::OFS_SYS_FLAG:
        begin
          nxt_rdat[rri_pkg::SYS_HWRST] = hwf_ff;
          nxt_rdat[rri_pkg::SYS_SW] = swf_ff;
        end
        rri_pkg::OFS_SYS_EN: nxt_rdat[rri_pkg::SYS_HWRST] = hwen_ff;
        rri_pkg::OFS_STRAP: nxt_rdat[rri_pkg::STRAP_W-1:0] = addr_ff;
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      lforce_ff <= 1'b0;
      lpref_ff <= 1'b0;
      sen_ff <= '0;
      hwen_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      lforce_ff <= nxt_lforce;
      lpref_ff <= nxt_lpref;
      sen_ff <= nxt_sen;
      hwen_ff <= nxt_hwen;
    end
  end

  // Autoneg outcome
  always_comb
  begin
    nxt_st = st_ff;
    nxt_role = role_ff;
    nxt_pforce = pforce_ff;
    nxt_ppref = ppref_ff;
    case (st_ff)
      rri_pkg::AN_IDLE: nxt_st = rri_pkg::AN_BUSY;
      rri_pkg::AN_BUSY:
      begin
        if (an_link_poor || an_page_timeout)
          nxt_st = rri_pkg::AN_FAIL;
        else if (an_page_valid)
        begin
          nxt_role = role_w;
          nxt_pforce = partner_role_forced;
          nxt_ppref = partner_prefers_leader;
          if (role_w == rri_pkg::ROLE_FAULT)
            nxt_st = rri_pkg::AN_FAIL;
          else
            nxt_st = rri_pkg::AN_DONE;
        end
      end
      rri_pkg::AN_DONE: nxt_st = st_ff;
      // Only a restart leaves failure
      rri_pkg::AN_FAIL: nxt_st = st_ff;
      default: nxt_st = rri_pkg::AN_IDLE;
    endcase
    if (restart_w)
      nxt_st = rri_pkg::AN_BUSY;
    nxt_link = (nxt_st == rri_pkg::AN_DONE);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff <= rri_pkg::AN_IDLE;
      role_ff <= rri_pkg::ROLE_FOLLOWER;
      pforce_ff <= 1'b0;
      ppref_ff <= 1'b0;
      link_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      role_ff <= nxt_role;
      pforce_ff <= nxt_pforce;
      ppref_ff <= nxt_ppref;
      link_ff <= nxt_link;
    end
  end

  // Interrupts; a set wins over a clear in the same cycle
  always_comb
  begin
    sevt = '0;
    sevt[rri_pkg::STS_FRAME] = frame_chk_evt;
    sevt[rri_pkg::STS_BUF] = buf_err_evt;
    sevt[rri_pkg::STS_AN] = (nxt_st != st_ff);
    sevt[rri_pkg::STS_LINK] = (nxt_link != link_ff);
    nxt_sflag = sflag_ff;
    nxt_hwf = hwf_ff;
    nxt_swf = swf_ff;
    if (wr_w && hit(adr8, rri_pkg::OFS_STS_FLAG))
      nxt_sflag = sflag_ff & ~wb_dat_i[NS-1:0];
    if (wr_w && hit(adr8, rri_pkg::OFS_SYS_FLAG))
    begin
      nxt_hwf = hwf_ff & ~wb_dat_i[rri_pkg::SYS_HWRST];
      nxt_swf = swf_ff & ~wb_dat_i[rri_pkg::SYS_SW];
    end
    nxt_sflag = nxt_sflag | sevt;
    nxt_swf = nxt_swf | swreq_w;
    nxt_irq_n = !pend_w;
  end

  assign pend_w = |(sflag_ff & sen_ff)
                  || (hwf_ff && hwen_ff)
                  || swf_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sflag_ff <= '0;
      hwf_ff <= 1'b1;
      swf_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end
    else
    begin
      sflag_ff <= nxt_sflag;
      hwf_ff <= nxt_hwf;
      swf_ff <= nxt_swf;
      irq_n_ff <= nxt_irq_n;
    end
  end

  // Straps followed while reset is held, then frozen at release
  always_comb
  begin
    nxt_addr = addr_ff;
    if (!rst_n)
      nxt_addr = strap_s;
  end

  always_ff @(posedge clk)
  begin
    addr_ff <= nxt_addr;
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign int_n = irq_n_ff;
  assign link_up = link_ff;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic page_w;
  assign page_w = (st_ff == rri_pkg::AN_BUSY) && an_page_valid
                  && !an_link_poor && !an_page_timeout && !restart_w;

  a_ack_single: assert property (ack_ff |=> !ack_ff)
    else $error("ack held longer than one cycle");
  a_pref_differ: assert property (page_w && !lforce_ff
      && !partner_role_forced && lpref_ff != partner_prefers_leader
      |=> role_ff == ($past(lpref_ff) ? rri_pkg::ROLE_LEADER
                                      : rri_pkg::ROLE_FOLLOWER))
    else $error("differing preferences resolved wrongly");
  a_tie_random: assert property (page_w && !lforce_ff
      && !partner_role_forced && lpref_ff == partner_prefers_leader
      |=> role_ff != rri_pkg::ROLE_FAULT && link_ff)
    else $error("tie did not resolve to a role");
  a_one_forced: assert property (page_w && lforce_ff
      && !partner_role_forced
      |=> role_ff == ($past(lpref_ff) ? rri_pkg::ROLE_LEADER
                                      : rri_pkg::ROLE_FOLLOWER))
    else $error("forced side lost its role");
  a_both_forced: assert property (page_w && lforce_ff
      && partner_role_forced && lpref_ff == partner_prefers_leader
      |=> role_ff == rri_pkg::ROLE_FAULT && st_ff == rri_pkg::AN_FAIL)
    else $error("forced clash not reported as fault");
  a_fail_sticky: assert property (st_ff == rri_pkg::AN_FAIL
      && !restart_w |=> st_ff == rri_pkg::AN_FAIL && !link_ff)
    else $error("failed autoneg left without restart");
  a_pin_follows: assert property (##1 irq_n_ff == !$past(pend_w))
    else $error("interrupt pin disagrees with pending flags");
  a_sw_request: assert property (swreq_w
      |=> swf_ff ##1 !irq_n_ff)
    else $error("software request did not reach the pin");
  a_status_gate: assert property (sflag_ff[rri_pkg::STS_LINK]
      && !sen_ff[rri_pkg::STS_LINK] && !hwf_ff && !swf_ff
      && (sflag_ff & sen_ff) == '0 |=> irq_n_ff)
    else $error("masked status source drove the pin");
  a_hwrst_flag: assert property ($rose(rst_n) |-> hwf_ff)
    else $error("hardware reset flag not set after reset");

  c_fault: cover property (st_ff == rri_pkg::AN_FAIL
      && role_ff == rri_pkg::ROLE_FAULT);
  c_leader: cover property (link_ff && role_ff == rri_pkg::ROLE_LEADER);
  c_sw_irq: cover property (swreq_w ##2 !irq_n_ff);
  c_restart: cover property (st_ff == rri_pkg::AN_FAIL ##1 restart_w);
endmodule

// [sim/rri_partner.sv]
// Link partner model that sends autoneg pages with its role advert
module rri_partner (
  // Clock
  input wire logic clk,
  // Page toward the block
  output logic page_valid,
  output logic role_forced,
  output logic prefers_leader
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    page_valid = 1'b0;
    role_forced = 1'b0;
    prefers_leader = 1'b0;
  end
  // Advert is flipped after the page so stale bits never pass as valid
  task automatic send_page(input logic f, input logic p);
    @(posedge clk);
    page_valid <= 1'b1;
    role_forced <= f;
    prefers_leader <= p;
    @(posedge clk);
    page_valid <= 1'b0;
    role_forced <= ~f;
    prefers_leader <= ~p;
  endtask
endmodule

// [sim/rri_top_test.sv]
// Self-checking testbench for the role resolution and interrupt block
module rri_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, st;
  logic an_page_valid, partner_role_forced, partner_prefers_leader;
  logic an_link_poor, an_page_timeout, frame_chk_evt, buf_err_evt;
  logic int_n, link_up;
  int n_errors = 0;
  int tests_run = 0;

  rri_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .an_page_valid(an_page_valid),
    .partner_role_forced(partner_role_forced),
    .partner_prefers_leader(partner_prefers_leader),
    .an_link_poor(an_link_poor), .an_page_timeout(an_page_timeout),
    .frame_chk_evt(frame_chk_evt), .buf_err_evt(buf_err_evt),
    .phy_addr_strap_bit0(1'b1), .phy_addr_strap_bit1(1'b0),
    .phy_addr_strap_bit2(1'b1), .int_n(int_n), .link_up(link_up));

  rri_partner i_partner (.clk(clk), .page_valid(an_page_valid),
    .role_forced(partner_role_forced),
    .prefers_leader(partner_prefers_leader));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Classic single cycle; answer latency is not assumed
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
    else
    begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, adr, d, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr,
                        input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, st);
    check(name, exp, st & mask);
  endtask

  task automatic wait_int(input logic exp);
    int n;
    n = 0;
    while (int_n !== exp && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    check("int_n", exp, int_n);
    if (int_n !== exp)
      finish_test();
  endtask

  function automatic logic [1:0] exp_role(input logic lf, lp, pf, pp);
    if (lf && pf && lp == pp)
      return rri_pkg::ROLE_FAULT;
    if (lf)
      return lp ? rri_pkg::ROLE_LEADER : rri_pkg::ROLE_FOLLOWER;
    if (pf)
      return pp ? rri_pkg::ROLE_FOLLOWER : rri_pkg::ROLE_LEADER;
    if (lp != pp)
      return lp ? rri_pkg::ROLE_LEADER : rri_pkg::ROLE_FOLLOWER;
    return 2'h3;
  endfunction

  task automatic t_reset;
    check("int_n", 1'b1, int_n);
    rd_chk("sys_flag", rri_pkg::OFS_SYS_FLAG, 32'h3, 32'h1);
    rd_chk("strap", rri_pkg::OFS_STRAP, 32'h7, 32'h5);
    rd_chk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_sys_irq;
    wr(rri_pkg::OFS_SYS_EN, 32'h1);
    wait_int(1'b0);
    wr(rri_pkg::OFS_SYS_FLAG, 32'h1);
    wait_int(1'b1);
    wr(rri_pkg::OFS_SYS_EN, 32'h2);
    wait_int(1'b0);
    rd_chk("sys_flag", rri_pkg::OFS_SYS_FLAG, 32'h3, 32'h2);
    wr(rri_pkg::OFS_SYS_FLAG, 32'h2);
    wait_int(1'b1);
    wr(rri_pkg::OFS_SYS_EN, 32'h0);
  endtask

  task automatic t_roles;
    logic [1:0] er;
    logic flt;
    for (int i = 0; i < 16; i++)
    begin
      er = exp_role(i[3], i[2], i[1], i[0]);
      flt = (er == rri_pkg::ROLE_FAULT);
      wr(rri_pkg::OFS_AN_CTRL, {29'h0, 1'b1, i[3], i[2]});
      i_partner.send_page(i[1], i[0]);
      repeat (2) @(posedge clk);
      xfer(1'b0, rri_pkg::OFS_AN_STAT, 32'h0, st);
      check("an_stat_hi", 32'h0, st & 32'hFFFFFF80);
      if (er == 2'h3)
        check("role_tie", 1'b0, st[1]);
      else
        check("role", er, st[1:0]);
      check("stat", {i[0], i[1], !flt, flt, !flt}, st[6:2]);
      if (flt)
      begin
        i_partner.send_page(~i[1], ~i[0]);
        repeat (2) @(posedge clk);
        rd_chk("fault_held", rri_pkg::OFS_AN_STAT, 32'h13, 32'h2);
      end
    end
  endtask

  task automatic t_fail;
    for (int c = 0; c < 2; c++)
    begin
      wr(rri_pkg::OFS_AN_CTRL, 32'h5);
      an_link_poor <= (c == 0);
      an_page_timeout <= (c == 1);
      @(posedge clk);
      an_link_poor <= 1'b0;
      an_page_timeout <= 1'b0;
      i_partner.send_page(1'b0, 1'b0);
      repeat (2) @(posedge clk);
      check("link_up", 1'b0, link_up);
      rd_chk("fail", rri_pkg::OFS_AN_STAT, 32'h1C, 32'h08);
    end
    wr(rri_pkg::OFS_AN_CTRL, 32'h5);
    i_partner.send_page(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check("link_up", 1'b1, link_up);
  endtask

  task automatic t_sts_irq;
    wr(rri_pkg::OFS_STS_FLAG, 32'hF);
    wr(rri_pkg::OFS_STS_EN, 32'h1);
    buf_err_evt <= 1'b1;
    @(posedge clk);
    buf_err_evt <= 1'b0;
    repeat (3) @(posedge clk);
    check("int_n", 1'b1, int_n);
    rd_chk("sts_flag", rri_pkg::OFS_STS_FLAG, 32'hF, 32'h2);
    frame_chk_evt <= 1'b1;
    @(posedge clk);
    frame_chk_evt <= 1'b0;
    wait_int(1'b0);
    rd_chk("sts_flag", rri_pkg::OFS_STS_FLAG, 32'hF, 32'h3);
    wr(rri_pkg::OFS_STS_FLAG, 32'h1);
    wait_int(1'b1);
    wr(rri_pkg::OFS_STS_EN, 32'h4);
    wr(rri_pkg::OFS_AN_CTRL, 32'h5);
    i_partner.send_page(1'b0, 1'b0);
    wait_int(1'b0);
    rd_chk("sts_flag", rri_pkg::OFS_STS_FLAG, 32'h4, 32'h4);
    wr(rri_pkg::OFS_STS_FLAG, 32'hF);
    wr(rri_pkg::OFS_STS_EN, 32'h0);
    wait_int(1'b1);
  endtask

  // Reset in mid-run relatches the flag; a lane 0 strobe is needed
  task automatic t_hw_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("int_n", 1'b1, int_n);
    rd_chk("sys_flag", rri_pkg::OFS_SYS_FLAG, 32'h3, 32'h1);
    rd_chk("strap", rri_pkg::OFS_STRAP, 32'h7, 32'h5);
    wb_sel_i <= 4'hE;
    wr(rri_pkg::OFS_SYS_FLAG, 32'h1);
    wb_sel_i <= 4'hF;
    rd_chk("sel_ignored", rri_pkg::OFS_SYS_FLAG, 32'h1, 32'h1);
    wr(rri_pkg::OFS_SYS_EN, 32'h1);
    wait_int(1'b0);
    wr(rri_pkg::OFS_SYS_FLAG, 32'h1);
    wait_int(1'b1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    an_link_poor = 1'b0;
    an_page_timeout = 1'b0;
    frame_chk_evt = 1'b0;
    buf_err_evt = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sys_irq();
    t_roles();
    t_fail();
    t_sts_irq();
    t_hw_reset();
    finish_test();
  end
endmodule
